/* hw/pmg_pkg.sv */
// constants shared by the pin bank, switch outputs and general outputs
package pmg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register bus shape
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_PINS = 8;
    localparam int unsigned NUM_SW = 4;
    localparam int unsigned NUM_GPO = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [9:0] OFS_IRQ_SUMMARY = 10'h004;
    localparam logic [9:0] OFS_PIN_CTRL_BASE = 10'h0e0;
    localparam logic [9:0] OFS_PIN_FLAGS = 10'h0e8;
    localparam logic [9:0] OFS_SW_CTRL_BASE = 10'h0ec;
    localparam logic [9:0] OFS_GPO = 10'h0f4;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned BIT_DRIVE = 0;
    localparam int unsigned BIT_DIR = 1;
    localparam int unsigned BIT_LEVEL_IN = 2;
    localparam int unsigned BIT_LEVEL_OUT = 3;
    localparam int unsigned BIT_EDGE_LO = 4;
    localparam int unsigned BIT_DBNC_LO = 6;
    localparam int unsigned BIT_SUMMARY_PIN = 4;
    localparam logic [7:0] SW_CTRL_STORE_MASK = 8'hf9;
    localparam logic [7:0] PIN_CTRL_STORE_MASK = 8'hfb;

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RST_PIN_CTRL = 8'h02;
    localparam logic [7:0] RST_SW_CTRL = 8'h00;
    localparam logic [7:0] RST_GPO = 8'h00;
    localparam logic [7:0] RST_PIN_FLAGS = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned DBNC_STEP_MS = 10;
    localparam int unsigned LF_CLK_HZ = 32768;
    localparam int unsigned LF_EDGES_PER_MS = (LF_CLK_HZ + 999) / 1000;
    localparam int unsigned DBNC_CNT_W = 6;

    typedef enum logic [1:0] {
        PMG_EDGE_MASK = 2'h0,
        PMG_EDGE_FALL = 2'h1,
        PMG_EDGE_RISE = 2'h2,
        PMG_EDGE_BOTH = 2'h3
    } pmg_edge_t;

endpackage : pmg_pkg

/* hw/pmg_pin_if.sv */
// configuration and state carried between the register file and a pin cell
`timescale 1ns/1ps
`default_nettype none
interface pmg_pin_if;
    logic       drive_cmos;
    logic       dir_input;
    logic       out_level;
    logic [1:0] debounce_sel;
    logic       level_stable;

    modport ctrl (output drive_cmos, output dir_input, output out_level, output debounce_sel,
                  input level_stable);
    modport drv  (input drive_cmos, input dir_input, input out_level);
    modport dbnc (input debounce_sel, output level_stable);
endinterface : pmg_pin_if
`default_nettype wire

/* hw/pmg_debounce.sv */
// debounce filter for one synchronised input, counted in millisecond ticks
`timescale 1ns/1ps
`default_nettype none
module pmg_debounce
    import pmg_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic raw_i,
    input  wire logic ms_tick_i,
    pmg_pin_if.dbnc   cfg
);
    logic [DBNC_CNT_W-1:0] tick_cnt;
    logic                  stable;
    wire                   differs = raw_i ^ stable;
    // one tick more than the interval, since the first tick may be partial
    wire [DBNC_CNT_W-1:0]  limit = DBNC_CNT_W'(cfg.debounce_sel) * DBNC_CNT_W'(DBNC_STEP_MS);
    wire                   accept = (cfg.debounce_sel == 2'h0) || (ms_tick_i && (tick_cnt == limit));

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt <= '0;
            stable   <= 1'b0;
        end else begin
            if (!differs || accept)
                tick_cnt <= '0;
            else if (ms_tick_i)
                tick_cnt <= tick_cnt + 1'b1;
            if (differs && accept)
                stable <= raw_i;
        end
    end

    assign cfg.level_stable = stable;
endmodule : pmg_debounce
`default_nettype wire

/* hw/pmg_pin_driver.sv */
// registered output stage: level and enable for one open-drain or push-pull pin
`timescale 1ns/1ps
`default_nettype none
module pmg_pin_driver (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    pmg_pin_if.drv    cfg,
    output logic      pin_out_o,
    output logic      pin_oe_n_o
);
    // a high level on an open-drain pin releases it
    wire next_oe_n = cfg.dir_input || (cfg.out_level && !cfg.drive_cmos);
    wire next_out  = cfg.out_level && cfg.drive_cmos;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_out_o  <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else begin
            pin_out_o  <= next_out;
            pin_oe_n_o <= next_oe_n;
        end
    end
endmodule : pmg_pin_driver
`default_nettype wire

/* hw/pmg_gpio_bank.sv */
// pin bank, switch-gating outputs and general outputs behind the register port
`timescale 1ns/1ps
`default_nettype none
module pmg_gpio_bank
    import pmg_pkg::*;
#(
    parameter int unsigned LF_PER_MS = LF_EDGES_PER_MS
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   lf_clk_i,
    input  wire logic [pmg_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [pmg_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic [pmg_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                        reg_rvalid_o,
    input  wire logic [pmg_pkg::NUM_PINS-1:0] pin_level_i,
    output logic [pmg_pkg::NUM_PINS-1:0] pin_out_o,
    output logic [pmg_pkg::NUM_PINS-1:0] pin_oe_n_o,
    output logic [pmg_pkg::NUM_SW-1:0]  switch_gating_output_o,
    output logic [pmg_pkg::NUM_SW-1:0]  switch_oe_n_o,
    output logic [2*pmg_pkg::NUM_SW-1:0] ramp_resistance_sel_o,
    output logic [pmg_pkg::NUM_GPO-1:0] general_output_levels_o,
    output logic                        pin_irq_summary_o
);
    ////////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                      input int unsigned n);
        in_block = (a >= base) && (a < base + ADDR_W'(n));
    endfunction : in_block

    function automatic logic [2:0] block_index(input logic [ADDR_W-1:0] a,
                                               input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] d;
        d = a - base;
        block_index = d[2:0];
    endfunction : block_index

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [DATA_W-1:0]   pin_control_n [NUM_PINS];
    logic [DATA_W-1:0]   switch_output_control_n [NUM_SW];
    logic [NUM_GPO-1:0]  general_output_levels;
    logic [NUM_PINS-1:0] pin_interrupt_flags;
    logic                irq_summary;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire       hit_pin_ctrl = in_block(reg_addr_i, OFS_PIN_CTRL_BASE, NUM_PINS);
    wire       hit_sw_ctrl  = in_block(reg_addr_i, OFS_SW_CTRL_BASE, NUM_SW);
    wire       hit_flags    = (reg_addr_i == OFS_PIN_FLAGS);
    wire       hit_gpo      = (reg_addr_i == OFS_GPO);
    wire       hit_summary  = (reg_addr_i == OFS_IRQ_SUMMARY);
    wire [2:0] pin_idx      = block_index(reg_addr_i, OFS_PIN_CTRL_BASE);
    wire [2:0] sw_off       = block_index(reg_addr_i, OFS_SW_CTRL_BASE);
    wire [1:0] sw_idx       = sw_off[1:0];
    wire       wr_pin       = reg_wr_i && hit_pin_ctrl;
    wire       wr_sw        = reg_wr_i && hit_sw_ctrl;
    wire       wr_gpo       = reg_wr_i && hit_gpo;
    wire       rd_flags     = reg_rd_i && hit_flags;
    wire       rd_summary   = reg_rd_i && hit_summary;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and millisecond tick

    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic [2:0]          lf_sync;
    logic [15:0]         lf_cnt;
    logic                ms_tick;
    wire                 lf_rise = lf_sync[1] && !lf_sync[2];
    wire                 lf_wrap = (lf_cnt == 16'(LF_PER_MS - 1));

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            lf_sync  <= '0;
        end else begin
            pin_meta <= pin_level_i;
            pin_sync <= pin_meta;
            lf_sync  <= {lf_sync[1:0], lf_clk_i};
        end
    end

    // slow clock edges counted into a one-cycle millisecond tick
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lf_cnt  <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= lf_rise && lf_wrap;
            if (lf_rise)
                lf_cnt <= lf_wrap ? '0 : lf_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin cells and switch output cells

    logic [NUM_PINS-1:0] level_stable;
    logic [NUM_PINS-1:0] level_prev;
    logic [NUM_PINS-1:0] edge_hit;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            pmg_pin_if pif ();
            wire [1:0] edge_sel = pin_control_n[g][BIT_EDGE_LO +: 2];
            wire       rise     = level_stable[g] && !level_prev[g];
            wire       fall     = !level_stable[g] && level_prev[g];

            assign pif.drive_cmos   = pin_control_n[g][BIT_DRIVE];
            assign pif.dir_input    = pin_control_n[g][BIT_DIR];
            assign pif.out_level    = pin_control_n[g][BIT_LEVEL_OUT];
            assign pif.debounce_sel = pin_control_n[g][BIT_DBNC_LO +: 2];
            assign level_stable[g]  = pif.level_stable;

            assign edge_hit[g] = ((edge_sel == PMG_EDGE_FALL) && fall)
                              || ((edge_sel == PMG_EDGE_RISE) && rise)
                              || ((edge_sel == PMG_EDGE_BOTH) && (rise || fall));

            pmg_debounce u_dbnc (
                .ref_clk_i (ref_clk_i),
                .nrst_i    (nrst_i),
                .raw_i     (pin_sync[g]),
                .ms_tick_i (ms_tick),
                .cfg       (pif.dbnc)
            );

            pmg_pin_driver u_drv (
                .ref_clk_i  (ref_clk_i),
                .nrst_i     (nrst_i),
                .cfg        (pif.drv),
                .pin_out_o  (pin_out_o[g]),
                .pin_oe_n_o (pin_oe_n_o[g])
            );
        end

        for (g = 0; g < NUM_SW; g++) begin : g_sw
            pmg_pin_if sif ();

            assign sif.drive_cmos   = switch_output_control_n[g][BIT_DRIVE];
            assign sif.dir_input    = 1'b0;
            assign sif.out_level    = switch_output_control_n[g][BIT_LEVEL_OUT];
            assign sif.debounce_sel = 2'h0;
            // switch outputs have no input side
            assign sif.level_stable = 1'b0;

            pmg_pin_driver u_drv (
                .ref_clk_i  (ref_clk_i),
                .nrst_i     (nrst_i),
                .cfg        (sif.drv),
                .pin_out_o  (switch_gating_output_o[g]),
                .pin_oe_n_o (switch_oe_n_o[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_PINS; i++)
                pin_control_n[i] <= RST_PIN_CTRL;
        end else if (wr_pin) begin
            // the input level bit is not storage
            pin_control_n[pin_idx] <= reg_wdata_i & PIN_CTRL_STORE_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NUM_SW; i++)
                switch_output_control_n[i] <= RST_SW_CTRL;
        end else if (wr_sw) begin
            switch_output_control_n[sw_idx] <= reg_wdata_i & SW_CTRL_STORE_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            general_output_levels <= RST_GPO;
        else if (wr_gpo)
            general_output_levels <= reg_wdata_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags: a new edge wins over the clearing read

    wire [NUM_PINS-1:0] next_flags   = (rd_flags ? '0 : pin_interrupt_flags) | edge_hit;
    wire                next_summary = (rd_summary ? 1'b0 : irq_summary) | (|edge_hit);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_prev          <= '0;
            pin_interrupt_flags <= RST_PIN_FLAGS;
            irq_summary         <= 1'b0;
        end else begin
            level_prev          <= level_stable;
            pin_interrupt_flags <= next_flags;
            irq_summary         <= next_summary;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: data is captured on the read strobe itself

    logic [DATA_W-1:0] pin_rd_word;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        pin_rd_word = pin_control_n[pin_idx];
        pin_rd_word[BIT_LEVEL_IN] = level_stable[pin_idx];
    end

    // unmapped and reserved addresses read zero
    always_comb begin
        next_rdata = '0;
        if (hit_pin_ctrl)
            next_rdata = pin_rd_word;
        else if (hit_sw_ctrl)
            next_rdata = switch_output_control_n[sw_idx];
        else if (hit_flags)
            next_rdata = pin_interrupt_flags;
        else if (hit_gpo)
            next_rdata = general_output_levels;
        else if (hit_summary)
            next_rdata[BIT_SUMMARY_PIN] = irq_summary;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain outputs

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            general_output_levels_o <= RST_GPO;
            ramp_resistance_sel_o   <= '0;
            pin_irq_summary_o       <= 1'b0;
        end else begin
            general_output_levels_o <= general_output_levels;
            for (int i = 0; i < NUM_SW; i++)
                ramp_resistance_sel_o[2*i +: 2] <= switch_output_control_n[i][BIT_EDGE_LO +: 2];
            pin_irq_summary_o <= irq_summary;
        end
    end

endmodule : pmg_gpio_bank
`default_nettype wire

/* tb/pmg_platform_model.sv */
// platform side of the pin bank: sense sources that yield to the bank's own drivers
`timescale 1ns/1ps
`default_nettype none
module pmg_platform_model (
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_n_i,
    input  wire logic [7:0] ext_level_i,
    output logic      [7:0] pin_level_o
);
    // a driven pad shows the bank's level, a released one the sensor's
    assign pin_level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_level_i);
endmodule : pmg_platform_model
`default_nettype wire

/* tb/pmg_gpio_checker.sv */
// concurrent checks on the ports of the gpio bank
`timescale 1ns/1ps
`default_nettype none
module pmg_gpio_checker
    import pmg_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       nrst_i,
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    input wire logic [7:0] pin_out_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [3:0] switch_gating_output_o,
    input wire logic [3:0] switch_oe_n_o,
    input wire logic [7:0] ramp_resistance_sel_o,
    input wire logic [7:0] general_output_levels_o,
    input wire logic       pin_irq_summary_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [1:0] wr_q;
    logic [9:0] a1, a2;
    logic [7:0] d1, d2;
    // write strobe, address and data two edges back, when the drivers show it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) wr_q <= 2'h0;
        else wr_q <= {wr_q[0], reg_wr_i};
    end
    always_ff @(posedge ref_clk_i) begin
        a1 <= reg_addr_i;
        a2 <= a1;
        d1 <= reg_wdata_i;
        d2 <= d1;
    end
    wire logic pin2 = wr_q[1] && a2[9:3] == OFS_PIN_CTRL_BASE[9:3];
    wire logic sw2 = wr_q[1] && a2[9:2] == OFS_SW_CTRL_BASE[9:2];
    wire logic mapped = reg_addr_i == OFS_IRQ_SUMMARY || reg_addr_i[9:3] == OFS_PIN_CTRL_BASE[9:3]
                        || reg_addr_i == OFS_PIN_FLAGS || reg_addr_i[9:2] == OFS_SW_CTRL_BASE[9:2]
                        || reg_addr_i == OFS_GPO;
    property p_rd_answer; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    property p_rvalid_cause; reg_rvalid_o |-> $past(reg_rd_i); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read valid");
    property p_unmapped_zero; reg_rd_i && !mapped |=> reg_rdata_o == 8'h00; endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
    property p_pin_input; pin2 && d2[1] |-> pin_oe_n_o[a2[2:0]] && !pin_out_o[a2[2:0]]; endproperty
    a_pin_input: assert property (p_pin_input) else $error("input pin driven");
    property p_pin_drive;
        pin2 && !d2[1] |-> pin_out_o[a2[2:0]] == (d2[0] & d2[3]) && pin_oe_n_o[a2[2:0]] == (!d2[0] & d2[3]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive wrong");
    property p_sw_drive;
        sw2 |-> switch_gating_output_o[a2[1:0]] == (d2[0] & d2[3]) && switch_oe_n_o[a2[1:0]] == (!d2[0] & d2[3]);
    endproperty
    a_sw_drive: assert property (p_sw_drive) else $error("switch drive wrong");
    property p_sw_ramp; sw2 |-> ramp_resistance_sel_o[2*a2[1:0] +: 2] == d2[5:4]; endproperty
    a_sw_ramp: assert property (p_sw_ramp) else $error("ramp select wrong");
    property p_gpo_follow; wr_q[1] && a2 == OFS_GPO |-> general_output_levels_o == d2; endproperty
    a_gpo_follow: assert property (p_gpo_follow) else $error("general outputs wrong");
    property p_gpo_hold; $changed(general_output_levels_o) |-> wr_q[1] && a2 == OFS_GPO; endproperty
    a_gpo_hold: assert property (p_gpo_hold) else $error("general outputs moved");
    c_flag_read: cover property (reg_rd_i && reg_addr_i == OFS_PIN_FLAGS ##1 reg_rdata_o != 8'h00);
    c_summary: cover property (pin_irq_summary_o);
    c_gpo_rise: cover property ($rose(general_output_levels_o[0]));
endmodule : pmg_gpio_checker
bind pmg_gpio_bank pmg_gpio_checker u_chk (.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .pin_out_o, .pin_oe_n_o, .switch_gating_output_o,
    .switch_oe_n_o, .ramp_resistance_sel_o, .general_output_levels_o, .pin_irq_summary_o);
`default_nettype wire

/* tb/pmg_gpio_bank_tb.sv */
// self-checking bench for the gpio bank
`timescale 1ns/1ps
`default_nettype none
module pmg_gpio_bank_tb;
    import pmg_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       lf_clk_i = 1'b0;
    logic [9:0] reg_addr_i = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o, pin_level_i, pin_out_o, pin_oe_n_o, ramp_resistance_sel_o, general_output_levels_o;
    logic [3:0] switch_gating_output_o, switch_oe_n_o;
    logic       reg_rvalid_o, pin_irq_summary_o;
    logic [7:0] ext_level = 8'h00;
    logic [7:0] rd, w;
    logic [7:0] sw_vals [4] = '{8'hff, 8'h08, 8'h31, 8'hc1};
    logic [7:0] pin_vals [4] = '{8'h09, 8'h08, 8'h00, 8'h0a};
    int         mismatches = 0;
    int         tests_run = 0;
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    // slow clock stepped on the fast clock, one period every eight fast cycles
    initial forever begin
        repeat (4) @(posedge ref_clk_i);
        lf_clk_i <= ~lf_clk_i;
    end
    pmg_gpio_bank #(.LF_PER_MS(1)) uut (.ref_clk_i, .nrst_i, .lf_clk_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .pin_level_i, .pin_out_o, .pin_oe_n_o, .switch_gating_output_o,
        .switch_oe_n_o, .ramp_resistance_sel_o, .general_output_levels_o, .pin_irq_summary_o);
    pmg_platform_model u_plat (.pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .ext_level_i(ext_level),
        .pin_level_o(pin_level_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [9:0] a);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        // the answer stands for the one cycle after the strobe edge
        #1;
        check("read valid", {7'h0, reg_rvalid_o}, 8'h01);
        rd = reg_rdata_o;
    endtask : rd_reg
    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : settle
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        rd_reg(OFS_PIN_FLAGS); check("flags", rd, 8'h00);
        rd_reg(OFS_GPO); check("gpo", rd, 8'h00);
        rd_reg(OFS_PIN_CTRL_BASE); check("pin ctrl", rd, 8'h02);
        rd_reg(OFS_SW_CTRL_BASE); check("sw ctrl", rd, 8'h00);
        check("sw oe", {4'h0, switch_oe_n_o}, 8'h00);
        check("pin oe", pin_oe_n_o, 8'hff);
        wr(OFS_GPO, 8'ha5);
        settle();
        check("gpo out", general_output_levels_o, 8'ha5);
        rd_reg(OFS_GPO); check("gpo", rd, 8'ha5);
        wr(10'h0e9, 8'hff);
        rd_reg(10'h0e9); check("unmapped", rd, 8'h00);
        rd_reg(10'h300); check("unmapped", rd, 8'h00);
        for (int k = 0; k < 4; k++) begin
            w = sw_vals[k];
            wr(OFS_SW_CTRL_BASE + 10'(k), w);
            settle();
            check("sw out", {7'h0, switch_gating_output_o[k]}, {7'h0, w[0] & w[3]});
            check("sw oe", {7'h0, switch_oe_n_o[k]}, {7'h0, ~w[0] & w[3]});
            check("ramp", {6'h0, ramp_resistance_sel_o[2*k +: 2]}, {6'h0, w[5:4]});
            rd_reg(OFS_SW_CTRL_BASE + 10'(k)); check("sw ctrl", rd, w & 8'hf9);
        end
        for (int j = 0; j < 4; j++) begin
            w = pin_vals[j];
            wr(OFS_PIN_CTRL_BASE + 10'h1, w);
            settle();
            check("pin out", {7'h0, pin_out_o[1]}, {7'h0, ~w[1] & w[0] & w[3]});
            check("pin oe", {7'h0, pin_oe_n_o[1]}, {7'h0, w[1] | (~w[0] & w[3])});
        end
        rd_reg(OFS_PIN_CTRL_BASE + 10'h1); check("pin ctrl", rd, 8'h0a);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_PIN_CTRL_BASE + 10'h2, {2'h0, 2'(c), 4'h2});
            rd_reg(OFS_IRQ_SUMMARY);
            rd_reg(OFS_PIN_FLAGS);
            @(posedge ref_clk_i);
            ext_level[2] <= 1'b1;
            settle();
            repeat (8) @(posedge ref_clk_i);
            #1;
            check("summary out", {7'h0, pin_irq_summary_o}, {7'h0, c[1]});
            rd_reg(OFS_PIN_FLAGS); check("rise flag", rd, {5'h0, c[1], 2'h0});
            rd_reg(OFS_IRQ_SUMMARY); check("summary", rd, {3'h0, c[1], 4'h0});
            rd_reg(OFS_IRQ_SUMMARY); check("summary clr", rd, 8'h00);
            rd_reg(OFS_PIN_CTRL_BASE + 10'h2); check("level", rd & 8'h04, 8'h04);
            @(posedge ref_clk_i);
            ext_level[2] <= 1'b0;
            repeat (10) @(posedge ref_clk_i);
            rd_reg(OFS_PIN_FLAGS); check("fall flag", rd, {5'h0, c[0], 2'h0});
        end
        for (int c = 1; c < 4; c++) begin
            wr(OFS_PIN_CTRL_BASE + 10'h3, {2'(c), 6'h22});
            rd_reg(OFS_IRQ_SUMMARY);
            rd_reg(OFS_PIN_FLAGS);
            @(posedge ref_clk_i);
            ext_level[3] <= 1'b1;
            repeat (40 * c) @(posedge ref_clk_i);
            rd_reg(OFS_PIN_FLAGS); check("early", rd, 8'h00);
            repeat (48 * c + 60) @(posedge ref_clk_i);
            rd_reg(OFS_PIN_FLAGS); check("settled", rd, 8'h08);
            @(posedge ref_clk_i);
            ext_level[3] <= 1'b0;
            repeat (100 * c + 100) @(posedge ref_clk_i);
        end
        results();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        mismatches++;
        results();
    end
endmodule : pmg_gpio_bank_tb
`default_nettype wire
